// *** dlwl_core.sv ***
// Overview of operation
// - Mode register 1 bit 0 low disables the DLL until written back high.
// - DLL-off mode needs only CAS latency 10 with write latency 9.
// - DLL-off read strobe timing starts at AL plus CL minus one.
// - DLL-off shifts clock-to-strobe timing but keeps strobe-to-data unchanged.
// - After entry hold time in self refresh the clock is ignored.
// - Lock time written before self refresh relocks automatically; after needs reset.
// - Leveling samples clock level on rising strobe and feeds it back on data.
// - Device terminates strobes; controller terminates data lines during leveling.
// - Each byte lane levels separately, upper data for upper strobe.
// - Mode register 1 bit 7 enters and leaves write leveling.
// - Mode register 1 bit 12 disables output drivers when set.
// - In leveling, termination pin picks strobe nominal or park; data unterminated.
// - Leveling accepts every termination setting, output buffer on or off.
// - No dynamic termination in leveling; its field must read zero.
`timescale 1ns/1ps
`default_nettype none
module dlwl_core #(
	parameter int DATA_W = dlwl_pkg::MR_W,
	parameter int LANE_W = dlwl_pkg::LANE_W,
	parameter int DLL_LOCK_CYC = dlwl_pkg::DLL_LOCK_CYC
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic [dlwl_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [DATA_W-1:0] reg_rdata,
	input wire logic rd_cmd_pin,
	input wire logic odt_pin,
	input wire logic ck_level_pin,
	input wire logic upper_lane_strobe,
	input wire logic lower_lane_strobe,
	output logic [2*LANE_W-1:0] dq_out,
	output logic dq_oe,
	output logic strobe_term_en,
	output logic strobe_term_nominal,
	output logic dq_term_en,
	output logic dyn_term_en,
	output logic read_strobe_launch,
	output logic dll_enabled,
	output logic dll_locked,
	output logic clock_ignored
);
	localparam int LOCK_W = $clog2(DLL_LOCK_CYC + 1);
	localparam int LAT_W = dlwl_pkg::LAT_W;
	localparam int HOLD_W = dlwl_pkg::HOLD_W;

	logic [DATA_W-1:0] mode_reg [0:dlwl_pkg::MR_COUNT-1];
	dlwl_pkg::dlwl_pwr_t pwr_state;
	dlwl_pkg::dlwl_pwr_t next_pwr_state;
	logic [HOLD_W-1:0] hold_cnt;
	logic [LOCK_W-1:0] lock_cnt;
	logic [LAT_W-1:0] rd_cnt;
	logic mr6_in_sr;
	logic relock_needed;
	logic [1:0] strobe_prev;
	logic [4:0] pin_sync;

	// Every pin crosses two flops before any logic looks at it.
	dlwl_sync #(
		.WIDTH(5)
	) u_pin_sync (
		.clk(clk),
		.rst_n(rst_n),
		.ce(ce),
		.d({rd_cmd_pin, odt_pin, ck_level_pin, upper_lane_strobe, lower_lane_strobe}),
		.q(pin_sync)
	);

	wire logic rd_s = pin_sync[4];
	wire logic odt_s = pin_sync[3];
	wire logic ck_s = pin_sync[2];
	wire logic up_rise = pin_sync[1] & ~strobe_prev[1];
	wire logic lo_rise = pin_sync[0] & ~strobe_prev[0];

	// Register port decode.
	wire logic wr_mr = ce && reg_wr && (reg_addr < dlwl_pkg::MR7_IDX);
	wire logic wr_ctrl = ce && reg_wr && (reg_addr == dlwl_pkg::CTRL_IDX);
	wire logic mr0_wr = wr_mr && (reg_addr == dlwl_pkg::MR0_IDX);
	wire logic mr1_wr = wr_mr && (reg_addr == dlwl_pkg::MR1_IDX);
	wire logic mr6_wr = wr_mr && (reg_addr == dlwl_pkg::MR6_IDX);
	wire logic dll_reset_wr = mr0_wr && reg_wdata[dlwl_pkg::MR0_DLL_RESET_BIT];
	wire logic sr_enter_cmd = wr_ctrl && reg_wdata[dlwl_pkg::CTRL_SR_ENTER_BIT];
	wire logic sr_exit_cmd = wr_ctrl && reg_wdata[dlwl_pkg::CTRL_SR_EXIT_BIT];
	wire logic init_done_cmd = wr_ctrl && reg_wdata[dlwl_pkg::CTRL_INIT_DONE_BIT];

	// Mode fields.
	wire logic [DATA_W-1:0] mr0 = mode_reg[0];
	wire logic [DATA_W-1:0] mr1 = mode_reg[1];
	wire logic [DATA_W-1:0] mr2 = mode_reg[2];
	wire logic dll_on_cfg = mr1[dlwl_pkg::MR1_DLL_EN_BIT];
	wire logic wlevel = mr1[dlwl_pkg::MR1_WLEVEL_BIT];
	wire logic qoff = mr1[dlwl_pkg::MR1_QOFF_BIT];
	wire logic [1:0] al_code = mr1[dlwl_pkg::MR1_AL_LSB +: 2];
	wire logic [LAT_W-1:0] cl_val = LAT_W'(dlwl_pkg::CL_BASE)
		+ LAT_W'(mr0[dlwl_pkg::MR0_CL_LSB +: 3]);
	wire logic [LAT_W-1:0] cwl_val = LAT_W'(dlwl_pkg::CWL_BASE)
		+ LAT_W'(mr2[dlwl_pkg::MR2_CWL_LSB +: 3]);
	wire logic [LAT_W-1:0] al_val = (al_code == 2'h1) ? cl_val - 6'h01 :
		(al_code == 2'h2) ? cl_val - 6'h02 : 6'h00;
	// Without the DLL the strobe is referenced one clock earlier.
	wire logic [LAT_W-1:0] rd_delay = al_val + cl_val
		- (dll_on_cfg ? 6'h00 : 6'h01);
	// Only the fixed latency pair is guaranteed to work without the DLL.
	wire logic lat_bad = !dll_on_cfg && !((cl_val == LAT_W'(dlwl_pkg::DLL_OFF_CL))
		&& (cwl_val == LAT_W'(dlwl_pkg::DLL_OFF_CWL)));
	wire logic dyn_field_set = |mr2[dlwl_pkg::MR2_DYN_TERM_LSB +: dlwl_pkg::MR2_DYN_TERM_W];

	// Power state decode.
	wire logic in_sr = (pwr_state == dlwl_pkg::DLWL_SR_HOLD)
		|| (pwr_state == dlwl_pkg::DLWL_SR_IGNORE);
	wire logic clk_live = (pwr_state == dlwl_pkg::DLWL_INIT)
		|| (pwr_state == dlwl_pkg::DLWL_ACTIVE);
	wire logic sr_enter_take = sr_enter_cmd && (pwr_state == dlwl_pkg::DLWL_ACTIVE);
	wire logic sr_exit_take = sr_exit_cmd && in_sr;
	// Once the clock is ignored, no read or leveling strobe on the pins is acted upon; the ODT pin still is.
	wire logic read_take = ce && clk_live && rd_s && !wlevel;
	wire logic lvl_live = ce && clk_live && wlevel;
	wire logic auto_relock = sr_exit_take && !mr6_in_sr && dll_on_cfg;
	wire logic locked_int = dll_on_cfg && (lock_cnt == '0) && !relock_needed;

	logic [DATA_W-1:0] status_word;
	always_comb begin
		status_word = '0;
		status_word[dlwl_pkg::ST_INIT_DONE] = (pwr_state != dlwl_pkg::DLWL_INIT);
		status_word[dlwl_pkg::ST_DLL_ON] = dll_on_cfg;
		status_word[dlwl_pkg::ST_DLL_LOCKED] = locked_int;
		status_word[dlwl_pkg::ST_WLEVEL] = wlevel;
		status_word[dlwl_pkg::ST_SELF_REF] = in_sr;
		status_word[dlwl_pkg::ST_CLK_IGNORED] = (pwr_state == dlwl_pkg::DLWL_SR_IGNORE);
		status_word[dlwl_pkg::ST_LAT_BAD] = lat_bad;
		status_word[dlwl_pkg::ST_RELOCK_NEEDED] = relock_needed;
	end

	// The ignore register and the control register read as zero.
	wire logic [DATA_W-1:0] read_mux = (reg_addr < dlwl_pkg::MR7_IDX) ? mode_reg[reg_addr[2:0]] :
		(reg_addr == dlwl_pkg::STATUS_IDX) ? status_word : '0;

	always_comb begin
		next_pwr_state = pwr_state;
		unique case (pwr_state)
			dlwl_pkg::DLWL_INIT: begin
				if (init_done_cmd) begin
					next_pwr_state = dlwl_pkg::DLWL_ACTIVE;
				end
			end
			dlwl_pkg::DLWL_ACTIVE: begin
				if (sr_enter_cmd) begin
					next_pwr_state = dlwl_pkg::DLWL_SR_HOLD;
				end
			end
			dlwl_pkg::DLWL_SR_HOLD: begin
				if (sr_exit_cmd) begin
					next_pwr_state = dlwl_pkg::DLWL_ACTIVE;
				end else if (hold_cnt <= HOLD_W'(1)) begin
					next_pwr_state = dlwl_pkg::DLWL_SR_IGNORE;
				end
			end
			dlwl_pkg::DLWL_SR_IGNORE: begin
				if (sr_exit_cmd) begin
					next_pwr_state = dlwl_pkg::DLWL_ACTIVE;
				end
			end
		endcase
	end

	// Mode register image; the ignored register takes no write.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < dlwl_pkg::MR_COUNT; i++) begin
				mode_reg[i] <= (i == 1) ? dlwl_pkg::MR1_RESET : dlwl_pkg::MR_RESET;
			end
		end else if (wr_mr) begin
			mode_reg[reg_addr[2:0]] <= reg_wdata;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pwr_state <= dlwl_pkg::DLWL_INIT;
			hold_cnt <= '0;
		end else if (ce) begin
			pwr_state <= next_pwr_state;
			hold_cnt <= sr_enter_take ? HOLD_W'(dlwl_pkg::SRE_HOLD_CYC) :
				(hold_cnt != '0) ? hold_cnt - 8'h01 : hold_cnt;
		end
	end

	// A lock time written inside self refresh cannot be picked up on exit,
	// so the DLL then waits for an explicit reset through mode register 0.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mr6_in_sr <= 1'b0;
			relock_needed <= 1'b0;
			lock_cnt <= '0;
		end else if (ce) begin
			if (mr6_wr && in_sr) begin
				mr6_in_sr <= 1'b1;
			end else if (sr_exit_take || sr_enter_take) begin
				mr6_in_sr <= 1'b0;
			end
			if (sr_exit_take && mr6_in_sr) begin
				relock_needed <= 1'b1;
			end else if (dll_reset_wr) begin
				relock_needed <= 1'b0;
			end
			if (dll_reset_wr || auto_relock) begin
				lock_cnt <= LOCK_W'(DLL_LOCK_CYC);
			end else if (lock_cnt != '0) begin
				lock_cnt <= lock_cnt - LOCK_W'(1);
			end
		end
	end

	// Only one read in flight; a new read restarts the count.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_cnt <= '0;
			strobe_prev <= '0;
		end else if (ce) begin
			strobe_prev <= pin_sync[1:0];
			if (read_take) begin
				rd_cnt <= rd_delay;
			end else if (rd_cnt != '0) begin
				rd_cnt <= rd_cnt - 6'h01;
			end
		end
	end

	// Feedback is registered on the core clock; it trails the strobe edge
	// by the two synchroniser flops plus one clock, which the controller sweep tolerates.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			dq_out <= '0;
		end else if (ce) begin
			if (!wlevel) begin
				dq_out <= '0;
			end else begin
				if (lvl_live && up_rise) begin
					dq_out[2*LANE_W-1:LANE_W] <= {LANE_W{ck_s}};
				end
				if (lvl_live && lo_rise) begin
					dq_out[LANE_W-1:0] <= {LANE_W{ck_s}};
				end
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			dq_oe <= 1'b0;
			strobe_term_en <= 1'b0;
			strobe_term_nominal <= 1'b0;
			dq_term_en <= 1'b0;
			dyn_term_en <= 1'b0;
			read_strobe_launch <= 1'b0;
			dll_enabled <= 1'b1;
			dll_locked <= 1'b0;
			clock_ignored <= 1'b0;
			reg_rdata <= '0;
		end else if (ce) begin
			dq_oe <= wlevel && !qoff;
			// Termination follows the pin regardless of the output buffer.
			strobe_term_en <= 1'b1;
			strobe_term_nominal <= odt_s;
			dq_term_en <= !wlevel;
			dyn_term_en <= !wlevel && dyn_field_set;
			// Data and strobe leave together in both DLL modes.
			read_strobe_launch <= (rd_cnt == 6'h01);
			dll_enabled <= dll_on_cfg;
			dll_locked <= locked_int;
			clock_ignored <= (pwr_state == dlwl_pkg::DLWL_SR_IGNORE);
			reg_rdata <= reg_rd ? read_mux : '0;
		end
	end

	default clocking dlwl_cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	sequence dll_off_read_s;
		read_take && !dll_on_cfg && (cl_val == 6'd10) && (al_code == 2'h0)
			##1 (ce && !read_take && !reg_wr)[*8];
	endsequence

	sequence sr_entry_s;
		sr_enter_take ##1 (ce && !sr_exit_cmd)[*3];
	endsequence

	dll_off_a: assert property (mr1_wr && !reg_wdata[0] ##1 ce |=> !dll_enabled)
		else $error("DLL still enabled after disable write");

	dll_hold_a: assert property (!dll_on_cfg && !mr1_wr |=> !dll_on_cfg)
		else $error("DLL re-enabled without a mode register write");

	lat_pair_a: assert property (ce && !dll_on_cfg && (cl_val == 6'd10) && (cwl_val == 6'd9)
		|-> !status_word[dlwl_pkg::ST_LAT_BAD])
		else $error("Supported DLL-off latency pair flagged as bad");

	read_lat_a: assert property (dll_off_read_s |-> ##1 ce ##1 read_strobe_launch)
		else $error("DLL-off read strobe not at AL plus CL minus one");

	sr_ignore_a: assert property (sr_entry_s |-> clock_ignored)
		else $error("Clock not ignored after self refresh entry hold");

	sr_noread_a: assert property (clock_ignored |-> !read_take)
		else $error("Read accepted while clock is ignored");

	relock_a: assert property (sr_exit_take && mr6_in_sr |=> relock_needed && !locked_int)
		else $error("Late lock time did not demand a DLL reset");

	upper_lane_a: assert property (lvl_live && up_rise && !wr_mr
		|=> dq_out[2*LANE_W-1:LANE_W] == {LANE_W{$past(ck_s)}})
		else $error("Upper lane feedback does not match sampled clock");

	lane_split_a: assert property (lvl_live && up_rise && !lo_rise && !wr_mr
		|=> $stable(dq_out[LANE_W-1:0]))
		else $error("Upper strobe disturbed lower lane feedback");

	wl_enter_a: assert property (mr1_wr ##1 ce ##1 ce |-> dq_oe == ($past(reg_wdata[7], 2)
		&& !$past(reg_wdata[12], 2)))
		else $error("Leveling drive does not follow the mode write");

	qoff_a: assert property (ce && qoff |=> !dq_oe)
		else $error("Outputs driven with output buffer disabled");

	wl_term_a: assert property (ce && wlevel |=> !dq_term_en && strobe_term_en
		&& (strobe_term_nominal == $past(odt_s)))
		else $error("Leveling termination does not follow the pin");

	dyn_term_a: assert property (ce && wlevel |=> !dyn_term_en)
		else $error("Dynamic termination active during leveling");

endmodule // dlwl_core
`default_nettype wire

// *** dlwl_pkg.sv ***
package dlwl_pkg;

	// Register port geometry.
	localparam int ADDR_W = 4;
	localparam int MR_W = 18;
	localparam int LANE_W = 8;

	// Register indices on the plain register port.
	localparam logic [3:0] MR0_IDX = 4'h0;
	localparam logic [3:0] MR1_IDX = 4'h1;
	localparam logic [3:0] MR2_IDX = 4'h2;
	localparam logic [3:0] MR6_IDX = 4'h6;
	localparam logic [3:0] MR7_IDX = 4'h7;
	localparam logic [3:0] STATUS_IDX = 4'h8;
	localparam logic [3:0] CTRL_IDX = 4'h9;
	localparam int MR_COUNT = 7;

	// Mode register field positions.
	localparam int MR1_DLL_EN_BIT = 0;
	localparam int MR1_AL_LSB = 3;
	localparam int MR1_WLEVEL_BIT = 7;
	localparam int MR1_QOFF_BIT = 12;
	localparam int MR0_CL_LSB = 2;
	localparam int MR0_DLL_RESET_BIT = 8;
	localparam int MR2_CWL_LSB = 3;
	localparam int MR2_DYN_TERM_LSB = 9;
	localparam int MR2_DYN_TERM_W = 3;

	// Control register command bits, self clearing.
	localparam int CTRL_SR_ENTER_BIT = 0;
	localparam int CTRL_SR_EXIT_BIT = 1;
	localparam int CTRL_INIT_DONE_BIT = 2;

	// Status register bit positions.
	localparam int ST_INIT_DONE = 0;
	localparam int ST_DLL_ON = 1;
	localparam int ST_DLL_LOCKED = 2;
	localparam int ST_WLEVEL = 3;
	localparam int ST_SELF_REF = 4;
	localparam int ST_CLK_IGNORED = 5;
	localparam int ST_LAT_BAD = 6;
	localparam int ST_RELOCK_NEEDED = 7;

	// Values after reset: the DLL starts enabled, everything else cleared.
	localparam logic [MR_W-1:0] MR_RESET = 18'h00000;
	localparam logic [MR_W-1:0] MR1_RESET = 18'h00001;

	// Latency decoding.
	localparam int LAT_W = 6;
	localparam int CL_BASE = 9;
	localparam int CWL_BASE = 9;
	localparam int DLL_OFF_CL = 10;
	localparam int DLL_OFF_CWL = 9;

	// Timing.
	localparam int CLK_PERIOD_NS = 100;
	localparam int SRE_HOLD_NS = 10;
	localparam int SRE_HOLD_RAW = (SRE_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SRE_HOLD_CYC = (SRE_HOLD_RAW < 1) ? 1 : SRE_HOLD_RAW;
	localparam int HOLD_W = 8;
	localparam int DLL_LOCK_CYC = 768;

	typedef enum logic [1:0] {
		DLWL_INIT,
		DLWL_ACTIVE,
		DLWL_SR_HOLD,
		DLWL_SR_IGNORE
	} dlwl_pwr_t;

endpackage

// *** dlwl_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
module dlwl_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);
	logic [WIDTH-1:0] meta;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta <= '0;
			q <= '0;
		end else if (ce) begin
			meta <= d;
			q <= meta;
		end
	end
endmodule // dlwl_sync
`default_nettype wire

// *** dlwl_lvl_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module dlwl_lvl_model #(
	parameter int THRESH = 5
) (
	input wire logic clk,
	input wire logic start,
	input wire logic [7:0] lane_fb,
	output logic strobe,
	output var logic ck_level,
	output logic [3:0] delay,
	output logic done
);
	logic prev;
	// The clock edge sits THRESH delay steps after the strobe, so the sampled level flips there.
	assign ck_level = (delay >= THRESH);
	// Only strobe pulses go out; no command besides deselect is ever sent.
	// Feedback lines are received, never driven, so their termination is ours.
	initial begin
		strobe = 1'b0;
		delay = 4'h0;
		done = 1'b0;
		prev = 1'b0;
		forever begin
			@(posedge clk);
			if (start && !done) begin
				strobe <= 1'b1;
				repeat (6) @(posedge clk);
				if (!prev && lane_fb[0]) begin
					done <= 1'b1;
				end else begin
					delay <= delay + 4'h1;
				end
				prev = lane_fb[0];
				strobe <= 1'b0;
				repeat (2) @(posedge clk);
			end
		end
	end
endmodule // dlwl_lvl_model
`default_nettype wire

// *** tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb;
	localparam int LOCK = 8;
	localparam int THR = 5;
	logic clk;
	logic rst_n;
	logic ce;
	logic [3:0] reg_addr;
	logic [17:0] reg_wdata;
	logic reg_wr, reg_rd, rd_cmd_pin, odt_pin, ck_level, up_strobe, lo_strobe, lvl_start, lvl_done;
	logic [17:0] reg_rdata;
	logic [15:0] dq_out;
	logic [3:0] lvl_delay;
	logic dq_oe, st_en, st_nom, dq_term_en, dyn_term_en, launch, dll_en, dll_lock, clk_ign;
	int fail_count = 0;
	int n_compared = 0;
	int hp = 50;
	int l_on, l_off, l_al;

	dlwl_core #(.DLL_LOCK_CYC(LOCK)) i_dlwl_core (.clk(clk), .rst_n(rst_n), .ce(ce),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .rd_cmd_pin(rd_cmd_pin), .odt_pin(odt_pin),
		.ck_level_pin(ck_level), .upper_lane_strobe(up_strobe), .lower_lane_strobe(lo_strobe),
		.dq_out(dq_out), .dq_oe(dq_oe), .strobe_term_en(st_en), .strobe_term_nominal(st_nom),
		.dq_term_en(dq_term_en), .dyn_term_en(dyn_term_en), .read_strobe_launch(launch),
		.dll_enabled(dll_en), .dll_locked(dll_lock), .clock_ignored(clk_ign));
	dlwl_lvl_model #(.THRESH(THR)) i_dlwl_lvl_model (.clk(clk), .start(lvl_start),
		.lane_fb(dq_out[15:8]), .strobe(up_strobe), .ck_level(ck_level), .delay(lvl_delay),
		.done(lvl_done));

	initial begin
		clk = 1'b0;
		forever #(hp) clk = ~clk;
	end

	task automatic chk(input logic [17:0] seen, input logic [17:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fail_count++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic print_verdict();
		$display("compared %0d, mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic wr(input logic [3:0] a, input logic [17:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [17:0] exp);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		chk(reg_rdata, exp);
	endtask
	// Selector 0 watches the lock flag, any other value the leveling done flag.
	task automatic wait_for(input int sel, input logic v, input int n);
		logic s;
		for (int i = 0; i < n; i++) begin
			@(posedge clk);
			#1;
			s = (sel == 0) ? dll_lock : lvl_done;
			if (s === v) return;
		end
		fail_count++;
		print_verdict();
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic measure(output int n);
		n = 0;
		@(posedge clk);
		rd_cmd_pin <= 1'b1;
		@(posedge clk);
		rd_cmd_pin <= 1'b0;
		while (launch !== 1'b1 && n < 60) begin
			tick(1);
			n++;
		end
		if (n == 60) begin
			fail_count++;
			print_verdict();
		end
		tick(1);
		chk(18'(launch), 18'h00000);
	endtask
	// A refused read must leave the launch pulse silent for longer than any latency.
	task automatic no_launch();
		int seen;
		seen = 0;
		@(posedge clk);
		rd_cmd_pin <= 1'b1;
		@(posedge clk);
		rd_cmd_pin <= 1'b0;
		repeat (40) begin
			tick(1);
			if (launch === 1'b1) seen++;
		end
		chk(18'(seen), 18'h00000);
	endtask

	task automatic t_reset();
		tick(1);
		chk(18'(dll_en), 18'h00001);
		rd(4'h1, 18'h00001);
		rd(4'h0, 18'h00000);
		rd(4'h8, 18'h00006);
		wr(4'h8, 18'h3ffff);
		wr(4'h7, 18'h3ffff);
		rd(4'h8, 18'h00006);
		rd(4'h7, 18'h00000);
		rd(4'hc, 18'h00000);
		// With the clock enable low a write must not land.
		@(posedge clk);
		ce <= 1'b0;
		wr(4'h1, 18'h00000);
		ce <= 1'b1;
		rd(4'h1, 18'h00001);
	endtask
	// Still in initialization, so the DLL bit may be flipped freely.
	task automatic t_dll_off();
		wr(4'h0, 18'h00004);
		measure(l_on);
		wr(4'h1, 18'h00009);
		measure(l_al);
		chk(18'(l_al - l_on), 18'h00009);
		wr(4'h1, 18'h00011);
		measure(l_al);
		chk(18'(l_al - l_on), 18'h00008);
		wr(4'h1, 18'h00000);
		measure(l_off);
		chk(18'(l_on - l_off), 18'h00001);
		chk(18'(dll_en), 18'h00000);
		chk(18'(dll_lock), 18'h00000);
		rd(4'h8, 18'h00000);
		wr(4'h0, 18'h00000);
		rd(4'h8, 18'h00040);
		wr(4'h2, 18'h00008);
		wr(4'h0, 18'h00004);
		rd(4'h8, 18'h00040);
		wr(4'h2, 18'h00000);
		rd(4'h8, 18'h00000);
	endtask
	task automatic t_self_refresh();
		wr(4'h9, 18'h00004);
		wr(4'h5, 18'h00000);
		wr(4'h9, 18'h00001);
		tick(1);
		chk(18'(clk_ign), 18'h00000);
		tick(1);
		chk(18'(clk_ign), 18'h00001);
		rd(4'h8, 18'h00031);
		hp = 70;
		no_launch();
		wr(4'h1, 18'h00001);
		wr(4'h6, 18'h00000);
		hp = 50;
		tick(4);
		wr(4'h9, 18'h00002);
		tick(3);
		chk(18'(clk_ign), 18'h00000);
		tick(20);
		chk(18'(dll_lock), 18'h00000);
		rd(4'h8, 18'h00083);
		wr(4'h0, 18'h00104);
		wait_for(0, 1'b1, LOCK + 6);
		wr(4'h0, 18'h00004);
		wr(4'h5, 18'h00001);
		wr(4'h6, 18'h00000);
		wr(4'h9, 18'h00001);
		tick(4);
		wr(4'h9, 18'h00002);
		wait_for(0, 1'b0, 6);
		wait_for(0, 1'b1, LOCK + 6);
	endtask
	task automatic t_level();
		wr(4'h2, 18'h00200);
		tick(2);
		chk(18'(dyn_term_en), 18'h00001);
		wr(4'h2, 18'h00000);
		wr(4'h1, 18'h00081);
		odt_pin <= 1'b1;
		tick(4);
		chk(18'(dq_oe), 18'h00001);
		chk(18'(dq_term_en), 18'h00000);
		chk(18'(dyn_term_en), 18'h00000);
		chk(18'(st_en), 18'h00001);
		chk(18'(st_nom), 18'h00001);
		rd(4'h8, 18'h0000f);
		no_launch();
		@(posedge clk);
		lvl_start <= 1'b1;
		wait_for(1, 1'b1, 400);
		chk(18'(lvl_delay), 18'(THR));
		chk(18'(dq_out), 18'h0ff00);
		@(posedge clk);
		lo_strobe <= 1'b1;
		repeat (6) @(posedge clk);
		lo_strobe <= 1'b0;
		tick(0);
		chk(18'(dq_out), 18'h0ffff);
		wr(4'h1, 18'h01081);
		odt_pin <= 1'b0;
		tick(4);
		chk(18'(dq_oe), 18'h00000);
		chk(18'(st_nom), 18'h00000);
		chk(18'(st_en), 18'h00001);
		wr(4'h1, 18'h00001);
		tick(4);
		chk(18'(dq_out), 18'h00000);
		chk(18'(dq_term_en), 18'h00001);
	endtask

	initial begin
		rst_n = 1'b0;
		ce = 1'b1;
		reg_addr = 4'h0;
		reg_wdata = 18'h00000;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		rd_cmd_pin = 1'b0;
		odt_pin = 1'b0;
		lo_strobe = 1'b0;
		lvl_start = 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		t_reset();
		t_dll_off();
		t_self_refresh();
		t_level();
		print_verdict();
	end
endmodule // tb
`default_nettype wire
